/* logic/io_port_ctrl.sv */
// The implementer's own choices: the address map and register access over Wishbone.
`timescale 1ns/1ps
// two 8-bit ports with per-pin drive mode, wishbone register access
module io_port_ctrl #(
  parameter int PORTS = 2,
  parameter int PINS  = 8
) (
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic               we_i,
  input  wire logic [4:0]         adr_i,
  input  wire logic [3:0]         sel_i,
  input  wire logic [31:0]        dat_i,
  output logic      [31:0]        dat_o,
  output logic                    ack_o,
  input  wire logic [PORTS*PINS-1:0] pin_i,
  output logic      [PORTS*PINS-1:0] weak_o,
  output logic      [PORTS*PINS-1:0] medium_o,
  output logic      [PORTS*PINS-1:0] strong_o,
  output logic      [PORTS*PINS-1:0] pulldown_o
);
  logic [PORTS*PINS-1:0] pin_meta_q;
  logic [PORTS*PINS-1:0] pin_sync_q;
  logic [7:0]            latch_q [PORTS];
  logic [7:0]            pin_mode_cfg_lo_q [PORTS];
  logic [7:0]            pin_mode_cfg_hi_q [PORTS];
  logic                  req;
  logic                  wr_en;
  logic [31:0]           rd_d;

  assign req   = cyc_i && stb_i && !ack_o;
  assign wr_en = req && we_i && sel_i[0];

  // two-flop synchroniser: pins are asynchronous to clk_i
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= pin_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  // register writes; reset puts every pin in quasi mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int p = 0; p < PORTS; p++) begin
        latch_q[p]           <= io_port_pkg::LATCH_RESET;
        pin_mode_cfg_lo_q[p] <= io_port_pkg::CFG_RESET;
        pin_mode_cfg_hi_q[p] <= io_port_pkg::CFG_RESET;
      end
    end else if (wr_en) begin
      case (adr_i)
        io_port_pkg::ADDR_P0_LATCH:  latch_q[0]           <= dat_i[7:0];
        io_port_pkg::ADDR_P0_CFG_LO: pin_mode_cfg_lo_q[0] <= dat_i[7:0];
        io_port_pkg::ADDR_P0_CFG_HI: pin_mode_cfg_hi_q[0] <= dat_i[7:0];
        io_port_pkg::ADDR_P1_LATCH:  latch_q[1]           <= dat_i[7:0];
        io_port_pkg::ADDR_P1_CFG_LO: pin_mode_cfg_lo_q[1] <= dat_i[7:0];
        io_port_pkg::ADDR_P1_CFG_HI: pin_mode_cfg_hi_q[1] <= dat_i[7:0];
        default: ;
      endcase
    end
  end

  // read mux; pin registers show the synchronised level in every mode
  always_comb begin
    rd_d = 32'h0000_0000;
    case (adr_i)
      io_port_pkg::ADDR_P0_LATCH:  rd_d[7:0] = latch_q[0];
      io_port_pkg::ADDR_P0_CFG_LO: rd_d[7:0] = pin_mode_cfg_lo_q[0];
      io_port_pkg::ADDR_P0_CFG_HI: rd_d[7:0] = pin_mode_cfg_hi_q[0];
      io_port_pkg::ADDR_P0_PINS:   rd_d[7:0] = pin_sync_q[7:0];
      io_port_pkg::ADDR_P1_LATCH:  rd_d[7:0] = latch_q[1];
      io_port_pkg::ADDR_P1_CFG_LO: rd_d[7:0] = pin_mode_cfg_lo_q[1];
      io_port_pkg::ADDR_P1_CFG_HI: rd_d[7:0] = pin_mode_cfg_hi_q[1];
      io_port_pkg::ADDR_P1_PINS:   rd_d[7:0] = pin_sync_q[15:8];
      default:                     rd_d = 32'h0000_0000;
    endcase
  end

  // one-cycle ack, registered the cycle after the request, one answer per request; unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req;
      if (req) begin
        dat_o <= rd_d;
      end
    end
  end

  // one driver per pin; mode bits picked per pin index
  for (genvar p = 0; p < 2; p++) begin : g_port
    for (genvar y = 0; y < 8; y++) begin : g_pin
      logic [1:0] mode;
      if (y < 4) begin : g_lo
        assign mode = pin_mode_cfg_lo_q[p][2*y+1 : 2*y];
      end else begin : g_hi
        assign mode = pin_mode_cfg_hi_q[p][2*y-7 : 2*y-8];
      end
      io_pin_driver u_drv (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .mode_i     (mode),
        .latch_i    (latch_q[p][y]),
        .pin_i      (pin_sync_q[p*8+y]),
        .weak_o     (weak_o[p*8+y]),
        .medium_o   (medium_o[p*8+y]),
        .strong_o   (strong_o[p*8+y]),
        .pulldown_o (pulldown_o[p*8+y])
      );
    end
  end

  a_ack_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack after request");
  a_reset_quasi: assert property (@(posedge clk_i)
    $past(rst_i) |-> pin_mode_cfg_lo_q[0] == 8'h00 && pin_mode_cfg_hi_q[1] == 8'h00)
    else $error("mode not quasi after reset");
  a_cfg_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en && adr_i == io_port_pkg::ADDR_P0_CFG_LO |=> pin_mode_cfg_lo_q[0] == $past(dat_i[7:0]))
    else $error("config write lost");
  a_pin_read: assert property (@(posedge clk_i) disable iff (rst_i)
    req && !we_i && adr_i == io_port_pkg::ADDR_P0_PINS |=> dat_o[7:0] == $past(pin_sync_q[7:0]))
    else $error("pin read wrong");
endmodule

/* logic/io_port_pkg.sv */
package io_port_pkg;
  // drive mode codes
  localparam logic [1:0] MODE_QUASI     = 2'h0;
  localparam logic [1:0] MODE_PUSH_PULL = 2'h1;
  localparam logic [1:0] MODE_INPUT     = 2'h2;
  localparam logic [1:0] MODE_OPEN      = 2'h3;
  // byte addresses of registers, word aligned
  localparam logic [4:0] ADDR_P0_LATCH  = 5'h00;
  localparam logic [4:0] ADDR_P0_CFG_LO = 5'h04;
  localparam logic [4:0] ADDR_P0_CFG_HI = 5'h08;
  localparam logic [4:0] ADDR_P0_PINS   = 5'h0c;
  localparam logic [4:0] ADDR_P1_LATCH  = 5'h10;
  localparam logic [4:0] ADDR_P1_CFG_LO = 5'h14;
  localparam logic [4:0] ADDR_P1_CFG_HI = 5'h18;
  localparam logic [4:0] ADDR_P1_PINS   = 5'h1c;
  // reset values
  localparam logic [7:0] CFG_RESET      = 8'h00;
  localparam logic [7:0] LATCH_RESET    = 8'hff;
  // strong pull-up pulse: two cpu clocks
  localparam int         STRONG_CYCLES  = 2;
endpackage

/* logic/io_pin_driver.sv */
`timescale 1ns/1ps
// one pin: mode decode, strong pulse timer, driver enables
module io_pin_driver (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] mode_i,
  input  wire logic       latch_i,
  input  wire logic       pin_i,
  output logic            weak_o,
  output logic            medium_o,
  output logic            strong_o,
  output logic            pulldown_o
);
  logic       latch_prev_q;
  logic [1:0] strong_cnt_q;
  logic       is_quasi;

  assign is_quasi = (mode_i == io_port_pkg::MODE_QUASI);

  // previous latch value for rise detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      latch_prev_q <= 1'b1;
    end else begin
      latch_prev_q <= latch_i;
    end
  end

  // strong pull-up pulse counter, restarted on every latch rise in quasi mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strong_cnt_q <= 2'h0;
    end else if (is_quasi && latch_i && !latch_prev_q) begin
      strong_cnt_q <= 2'(io_port_pkg::STRONG_CYCLES);
    end else if (strong_cnt_q != 2'h0) begin
      strong_cnt_q <= strong_cnt_q - 2'h1;
    end
  end

  // driver enables registered so each output comes from a flip-flop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      weak_o     <= 1'b0;
      medium_o   <= 1'b0;
      strong_o   <= 1'b0;
      pulldown_o <= 1'b0;
    end else begin
      weak_o     <= is_quasi && latch_i;
      medium_o   <= is_quasi && latch_i && pin_i;
      // quasi strong pulse on rise, push-pull continuous; open/input never
      strong_o   <= (mode_i == io_port_pkg::MODE_PUSH_PULL && latch_i)
                 || (is_quasi && latch_i && ((!latch_prev_q) || strong_cnt_q == 2'h2));
      pulldown_o <= (mode_i != io_port_pkg::MODE_INPUT) && !latch_i;
    end
  end

  // strong pull-up lasts exactly two clocks after a quasi rise
  sequence s_rise;
    is_quasi && latch_i && !latch_prev_q;
  endsequence
  a_strong_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    s_rise ##1 (is_quasi && latch_i)[*2] |-> $past(strong_o) && strong_o)
    else $error("strong pull-up pulse not two clocks");
  a_input_float: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(mode_i == io_port_pkg::MODE_INPUT) |-> !weak_o && !medium_o && !strong_o && !pulldown_o)
    else $error("input-only pin driven");
  a_open_nopull: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && $past(mode_i == io_port_pkg::MODE_OPEN)
      |-> !weak_o && !medium_o && !strong_o && pulldown_o == !$past(latch_i))
    else $error("open drain drive wrong");
  a_quasi_weak: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && $past(is_quasi) |-> weak_o == $past(latch_i))
    else $error("weak pull-up does not follow latch");
  a_quasi_medium: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(is_quasi && latch_i && !pin_i) |-> !medium_o)
    else $error("medium pull-up on with pin low");
  a_push_strong: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && $past(mode_i == io_port_pkg::MODE_PUSH_PULL)
      |-> strong_o == $past(latch_i) && pulldown_o == !$past(latch_i))
    else $error("push-pull drive wrong");
  a_quasi_down: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && $past(is_quasi && !latch_i) |-> pulldown_o && !strong_o)
    else $error("quasi pull-down missing");
  // latch steady high for three samples rules out a fresh rise, so the pulse must be over
  a_strong_ends: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(is_quasi) && $past(latch_i) && $past(latch_i, 2) && $past(latch_i, 3) |-> !strong_o)
    else $error("strong pull-up stays on in quasi mode");
endmodule

/* verification/pad_model.sv */
`timescale 1ns/1ps
// board side of every pad: resistor, optional external low driver
module pad_model #(
  parameter logic [15:0] RES = 16'hffff
) (
  input  wire logic        clk_i,
  input  wire logic [15:0] up_i,
  input  wire logic [15:0] dn_i,
  input  wire logic [15:0] ext_low_i,
  output logic      [15:0] pin_o
);
  logic flt_q = 1'b0;
  // an undriven pad without resistor wanders, so it never settles to a level
  always_ff @(posedge clk_i) flt_q <= ~flt_q;
  // resistor lifts released pads, needed for open-drain outputs
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      pin_o[i] = (ext_low_i[i] | dn_i[i]) ? 1'b0 : (up_i[i] | RES[i]) ? 1'b1 : flt_q;
    end
  end
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic        clk_i   = 1'b0;
  logic        rst_i   = 1'b1;
  logic        cyc     = 1'b0;
  logic        stb     = 1'b0;
  logic        we      = 1'b0;
  logic [4:0]  adr     = 5'h00;
  logic [3:0]  sel     = 4'h0;
  logic [31:0] wdat    = 32'h0000_0000;
  logic [15:0] ext_low = 16'h0000;
  logic [31:0] rdat;
  logic [31:0] r;
  logic        ack;
  logic [15:0] pin;
  logic [15:0] wk;
  logic [15:0] md;
  logic [15:0] st;
  logic [15:0] pd;
  int          error_cnt = 0;
  int          n_tests   = 0;
  int          k;

  always #12.5 clk_i = ~clk_i;

  io_port_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .pin_i(pin), .weak_o(wk), .medium_o(md),
    .strong_o(st), .pulldown_o(pd));
  pad_model PAD (.clk_i(clk_i), .up_i(wk | md | st), .dn_i(pd), .ext_low_i(ext_low), .pin_o(pin));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // classic cycle held until ack is sampled, then idle one cycle
  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= s;
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) error_cnt++;
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  // settled {weak, medium, strong, pulldown}; pin assumed high unless pulled down
  function automatic logic [3:0] drv(input logic [1:0] m, input logic l);
    case (m)
      io_port_pkg::MODE_QUASI:     drv = l ? 4'hc : 4'h1;
      io_port_pkg::MODE_PUSH_PULL: drv = l ? 4'h2 : 4'h1;
      io_port_pkg::MODE_OPEN:      drv = l ? 4'h0 : 4'h1;
      default:                     drv = 4'h0;
    endcase
  endfunction

  task print_verdict;
    $display("mismatches %0d, checks %0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // about 4000 cycles, far beyond the roughly 150 the tests need
  initial begin
    #100000;
    error_cnt++;
    print_verdict;
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    wb(1'b0, io_port_pkg::ADDR_P0_CFG_LO, 8'h00, 4'hf);
    chk(r, 32'h0000_0000);
    wb(1'b0, io_port_pkg::ADDR_P1_CFG_HI, 8'h00, 4'hf);
    chk(r, 32'h0000_0000);
    chk({16'h0000, wk & md}, 32'h0000_ffff);
    chk({16'h0000, pd | st}, 32'h0000_0000);
    // lane 0 off: write is dropped
    wb(1'b1, io_port_pkg::ADDR_P0_LATCH, 8'h00, 4'he);
    wb(1'b0, io_port_pkg::ADDR_P0_LATCH, 8'h00, 4'hf);
    chk(r, 32'h0000_00ff);
    wb(1'b1, io_port_pkg::ADDR_P0_LATCH, 8'hfe, 4'h1);
    repeat (3) @(posedge clk_i);
    chk({28'h000_0000, wk[0], md[0], st[0], pd[0]}, 32'h0000_0001);
    // rising latch: count the strong pulse cycles
    // count alongside the write: the pulse starts before the bus task returns
    k = 0;
    fork
      wb(1'b1, io_port_pkg::ADDR_P0_LATCH, 8'hff, 4'h1);
      repeat (8) begin
        #1 k += int'(st[0]);
        @(posedge clk_i);
      end
    join
    chk(k, 2);
    // external device drags pin 1 low
    ext_low <= 16'h0002;
    repeat (5) @(posedge clk_i);
    chk({30'h0000_0000, wk[1], md[1]}, 32'h0000_0002);
    wb(1'b0, io_port_pkg::ADDR_P0_PINS, 8'h00, 4'hf);
    chk(r, 32'h0000_00fd);
    ext_low <= 16'h0000;
    // every mode on port 1 pins 2 and 6, both latch levels
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, io_port_pkg::ADDR_P1_CFG_LO, 8'(m << 4), 4'h1);
      wb(1'b1, io_port_pkg::ADDR_P1_CFG_HI, 8'(m << 4), 4'h1);
      wb(1'b0, io_port_pkg::ADDR_P1_CFG_HI, 8'h00, 4'hf);
      chk(r, 32'(m << 4));
      for (int l = 0; l < 2; l++) begin
        wb(1'b1, io_port_pkg::ADDR_P1_LATCH, l[0] ? 8'hff : 8'h00, 4'h1);
        repeat (6) @(posedge clk_i);
        chk({24'h00_0000, wk[10], md[10], st[10], pd[10], wk[14], md[14], st[14], pd[14]},
          {24'h00_0000, drv(2'(m), l[0]), drv(2'(m), l[0])});
      end
    end
    // open drain released: only the resistor holds pins 2 and 6 high
    wb(1'b0, io_port_pkg::ADDR_P1_PINS, 8'h00, 4'hf);
    chk(r, 32'h0000_00ff);
    print_verdict;
  end
endmodule
